/* design/mip_pkg.sv */
// constants, types and helpers shared by the multilevel interrupt prioritizer
package mip_pkg;
  localparam int NUM_SRC = 13;
  localparam int IDX_W = $clog2(NUM_SRC);
  localparam int VEC_W = 16;
  typedef logic [VEC_W-1:0] mip_word_addr_t;
  typedef logic [IDX_W-1:0] mip_idx_t;
  typedef logic [NUM_SRC-1:0] mip_mask_t;
  typedef logic [2:0] mip_rank_t;
  typedef logic [3:0] mip_act_t;
  typedef enum logic [1:0] {LVL_OFF, LVL_LOW, LVL_MED, LVL_HIGH} mip_level_t;

  // ranks, higher wins; active bit r-1 marks a running handler of rank r
  localparam mip_rank_t RANK_NONE = 3'h0;
  localparam mip_rank_t RANK_LOW = 3'h1;
  localparam mip_rank_t RANK_MED = 3'h2;
  localparam mip_rank_t RANK_HIGH = 3'h3;
  localparam mip_rank_t RANK_NMI = 3'h4;
  localparam mip_act_t ACT_RST = 4'h0;

  // word addresses in program memory
  localparam mip_word_addr_t OSC_FAIL_VECTOR = 16'h0002;
  localparam mip_word_addr_t PORT_R_PIN_VECTOR = 16'h0004;
  localparam mip_word_addr_t DMA_VECTOR_BASE = 16'h0006;
  localparam mip_word_addr_t RTC_VECTOR_BASE = 16'h000E;
  localparam mip_word_addr_t TIMER_C_FOUR_CH_VECTOR_BASE = 16'h0018;
  localparam mip_word_addr_t TIMER_C_TWO_CH_VECTOR_BASE = 16'h0024;
  localparam mip_word_addr_t ADC_VECTOR_BASE = 16'h0044;
  localparam mip_word_addr_t SERIAL_D_VECTOR_BASE = 16'h0050;
  localparam mip_word_addr_t BOOT_SECTION_WORD = 16'h2000;
  localparam mip_word_addr_t APP_SECTION_WORD = 16'h0000;
  localparam mip_word_addr_t OFS_0 = 16'h0000;
  localparam mip_word_addr_t OFS_1 = 16'h0002;

  // source table, sorted by ascending vector; index 0 is the oscillator failure event
  localparam mip_idx_t NMI_SRC = mip_idx_t'(0);
  localparam mip_idx_t LAST_LOW_RST = mip_idx_t'(NUM_SRC - 1);
  localparam mip_word_addr_t SRC_BASE [NUM_SRC] = '{OSC_FAIL_VECTOR, PORT_R_PIN_VECTOR,
    DMA_VECTOR_BASE, DMA_VECTOR_BASE, RTC_VECTOR_BASE, RTC_VECTOR_BASE,
    TIMER_C_FOUR_CH_VECTOR_BASE, TIMER_C_FOUR_CH_VECTOR_BASE, TIMER_C_TWO_CH_VECTOR_BASE,
    TIMER_C_TWO_CH_VECTOR_BASE, ADC_VECTOR_BASE, SERIAL_D_VECTOR_BASE, SERIAL_D_VECTOR_BASE};
  localparam mip_word_addr_t SRC_OFS [NUM_SRC] = '{OFS_0, OFS_0, OFS_0, OFS_1, OFS_0, OFS_1,
    OFS_0, OFS_1, OFS_0, OFS_1, OFS_0, OFS_0, OFS_1};

  // wake-up halt length in core clock cycles
  localparam logic [2:0] WAKE_HALT_CYCLES = 3'h4;
  localparam logic [2:0] HALT_CNT_RST = 3'h0;

  typedef struct packed {
    logic enable;
    mip_level_t level;
  } mip_src_cfg_t;

  typedef struct packed {
    logic valid;
    mip_rank_t rank;
    mip_word_addr_t vector;
  } mip_core_req_t;

  localparam mip_core_req_t CORE_REQ_RST = '{valid: 1'b0, rank: RANK_NONE, vector: APP_SECTION_WORD};

  // lowest set index of a mask, zero when empty
  function automatic mip_idx_t mip_first_set(input mip_mask_t m);
    mip_idx_t r;
    r = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = mip_idx_t'(i);
      end
    end
    return r;
  endfunction : mip_first_set

  // mask of all indices strictly above k
  function automatic mip_mask_t mip_above(input mip_idx_t k);
    mip_mask_t r;
    r = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      r[i] = (i > int'(k));
    end
    return r;
  endfunction : mip_above

  // vector of a source: peripheral base plus offset, moved to the boot section on request
  function automatic mip_word_addr_t mip_vec_of(input mip_idx_t i, input logic boot,
                                                input mip_word_addr_t bootStart);
    return SRC_BASE[i] + SRC_OFS[i] + (boot ? bootStart : APP_SECTION_WORD);
  endfunction : mip_vec_of

  // rank of the highest running handler
  function automatic mip_rank_t mip_top_rank(input mip_act_t a);
    return a[3] ? RANK_NMI : a[2] ? RANK_HIGH : a[1] ? RANK_MED : a[0] ? RANK_LOW : RANK_NONE;
  endfunction : mip_top_rank

  // active bit belonging to a rank
  function automatic mip_act_t mip_rank_bit(input mip_rank_t r);
    return (r == RANK_NONE) ? 4'h0 : mip_act_t'(4'h1 << (r - RANK_LOW));
  endfunction : mip_rank_bit
endpackage : mip_pkg

/* design/mip_prioritizer.sv */
// multilevel interrupt prioritizer: arbitration, dispatch to the core and wake-up halt
//
// How it works
// - every source except the oscillator failure event (index 0) picks low, medium or high level on its own
// - each source has its own enable, level and a distinct vector
// - an enabled source requests while its condition is present
// - on acknowledge the program counter is loaded with the request's vector
// - a medium request may preempt a running low handler
// - a high request may preempt a running medium or low handler
// - within one level the lowest vector address wins
// - low level offers a selectable round-robin order
// - a non-maskable class ignores the level enables
// - vector equals peripheral base plus interrupt offset
// - all vectors and bases are word addresses
// - the vector table can move between application and boot section
// - oscillator and PLL failure uses word 0x0002 and is non-maskable
// - port R at 0x0004, DMA base 0x0006, real-time counter base 0x000E
// - four-channel timer base 0x0018, two-channel timer base 0x0024
// - converter base 0x0044, serial port D base 0x0050
// - on wake-up, higher pending requests are dispatched before the waking one
// - after wake-up the core stays halted four cycles
`timescale 1ns/100ps
module mip_prioritizer #(
  parameter mip_pkg::mip_word_addr_t BOOT_START = mip_pkg::BOOT_SECTION_WORD
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [mip_pkg::NUM_SRC-1:0] srcCond,
  input wire mip_pkg::mip_src_cfg_t [mip_pkg::NUM_SRC-1:0] srcCfg,
  input wire logic [2:0] lvlEnable,
  input wire logic globalIntEn,
  input wire logic roundRobinEn,
  input wire logic vectorsInBoot,
  input wire logic sleepActive,
  input wire logic intAck,
  input wire logic retiDone,
  output mip_pkg::mip_core_req_t coreReq,
  output logic pcLoad,
  output mip_pkg::mip_word_addr_t pcVector,
  output logic [mip_pkg::NUM_SRC-1:0] srcAck,
  output logic [3:0] activeLevels,
  output logic cpuHalt,
  output logic wakeUp
);
  import mip_pkg::*;

  typedef enum logic {ST_RUN, ST_WAKE} mip_state_t;

  // ****************************************
  // declarations
  // ****************************************
  mip_core_req_t coreReq_reg;
  mip_core_req_t coreReq_next;
  logic pcLoad_reg;
  mip_word_addr_t pcVector_reg;
  mip_mask_t srcAck_reg;
  mip_mask_t srcAck_next;
  mip_act_t activeLevels_reg;
  mip_act_t activeLevels_next;
  mip_idx_t reqIdx_reg;
  mip_idx_t lastLow_reg;
  mip_idx_t lastLow_next;
  mip_state_t state_reg;
  mip_state_t state_next;
  logic [2:0] haltCnt_reg;
  logic [2:0] haltCnt_next;
  logic cpuHalt_reg;
  logic wakeUp_reg;

  mip_mask_t srcEnVec;
  mip_mask_t srcReq;
  mip_mask_t lowMask;
  mip_mask_t medMask;
  mip_mask_t highMask;
  mip_mask_t lowG;
  mip_mask_t medG;
  mip_mask_t highG;
  mip_mask_t lowAbove;
  mip_idx_t lowIdx;
  mip_idx_t highFirst;
  mip_idx_t winIdx;
  mip_rank_t winRank;
  mip_rank_t activeRank;
  mip_act_t retiMask;
  mip_act_t ackSetMask;
  logic nmiPend;
  logic eligible;
  logic runOk;
  logic ackTaken;
  logic wakeStart;

  // ****************************************
  // request collection
  // ****************************************
  // each source owns enable and level; index 0 ignores its level field
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
    assign srcEnVec[g] = srcCfg[g].enable;
    assign lowMask[g] = srcReq[g] && (srcCfg[g].level == LVL_LOW) && (g != int'(NMI_SRC));
    assign medMask[g] = srcReq[g] && (srcCfg[g].level == LVL_MED) && (g != int'(NMI_SRC));
    assign highMask[g] = srcReq[g] && (srcCfg[g].level == LVL_HIGH) && (g != int'(NMI_SRC));
  end

  // condition gated by the source's own enable
  assign srcReq = srcCond & srcEnVec;

  // level enables and global flag mask maskable levels only
  assign lowG = lowMask & {NUM_SRC{globalIntEn && lvlEnable[0]}};
  assign medG = medMask & {NUM_SRC{globalIntEn && lvlEnable[1]}};
  assign highG = highMask & {NUM_SRC{globalIntEn && lvlEnable[2]}};
  assign nmiPend = srcReq[NMI_SRC];

  // ****************************************
  // arbitration
  // ****************************************
  // round robin searches above the last granted low source, then wraps
  assign lowAbove = lowG & mip_above(lastLow_reg);
  assign lowIdx = (roundRobinEn && (|lowAbove)) ? mip_first_set(lowAbove) : mip_first_set(lowG);
  assign highFirst = mip_first_set(highG);

  // non-maskable first, then high, medium, low; lowest index is lowest vector
  assign winRank = nmiPend ? RANK_NMI :
                   (|highG) ? RANK_HIGH :
                   (|medG) ? RANK_MED :
                   (|lowG) ? RANK_LOW : RANK_NONE;
  assign winIdx = nmiPend ? NMI_SRC :
                  (|highG) ? highFirst :
                  (|medG) ? mip_first_set(medG) : lowIdx;

  // a request is offered only above the highest running handler
  assign activeRank = mip_top_rank(activeLevels_reg);
  assign eligible = (winRank > activeRank);

  // the core takes nothing while asleep or halted after wake-up
  assign runOk = (state_reg == ST_RUN) && !sleepActive;
  assign ackTaken = intAck && coreReq_reg.valid;

  // offered request; dropped for the cycle after an acknowledge so it is not taken twice
  assign coreReq_next = '{valid: eligible && runOk && !ackTaken,
                          rank: winRank,
                          vector: mip_vec_of(winIdx, vectorsInBoot, BOOT_START)};

  // ****************************************
  // handler bookkeeping
  // ****************************************
  // return clears the top running level, acknowledge marks the new one
  assign retiMask = retiDone ? mip_rank_bit(activeRank) : 4'h0;
  assign ackSetMask = ackTaken ? mip_rank_bit(coreReq_reg.rank) : 4'h0;
  assign activeLevels_next = (activeLevels_reg & ~retiMask) | ackSetMask;

  // one-cycle clear pulse back to the granted source
  assign srcAck_next = ackTaken ? (mip_mask_t'(1) << reqIdx_reg) : '0;
  assign lastLow_next = (ackTaken && (coreReq_reg.rank == RANK_LOW)) ? reqIdx_reg : lastLow_reg;

  // ****************************************
  // wake-up halt
  // ****************************************
  assign wakeStart = (state_reg == ST_RUN) && sleepActive && eligible;

  // halt sequencer: four cycles of halt, then dispatch by priority
  always_comb begin
    state_next = state_reg;
    haltCnt_next = haltCnt_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (wakeStart) begin
          state_next = ST_WAKE;
          haltCnt_next = WAKE_HALT_CYCLES - 3'h1;
        end
      end
      ST_WAKE: begin
        if (haltCnt_reg == HALT_CNT_RST) begin
          state_next = ST_RUN;
        end else begin
          haltCnt_next = haltCnt_reg - 3'h1;
        end
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  // request and dispatch path
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      coreReq_reg <= CORE_REQ_RST;
      pcLoad_reg <= 1'b0;
      pcVector_reg <= APP_SECTION_WORD;
      srcAck_reg <= '0;
      reqIdx_reg <= NMI_SRC;
    end else begin
      coreReq_reg <= coreReq_next;
      pcLoad_reg <= ackTaken;
      pcVector_reg <= ackTaken ? coreReq_reg.vector : pcVector_reg;
      srcAck_reg <= srcAck_next;
      reqIdx_reg <= winIdx;
    end
  end

  // level state, round-robin pointer and halt sequencer
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      activeLevels_reg <= ACT_RST;
      lastLow_reg <= LAST_LOW_RST;
      state_reg <= ST_RUN;
      haltCnt_reg <= HALT_CNT_RST;
      cpuHalt_reg <= 1'b0;
      wakeUp_reg <= 1'b0;
    end else begin
      activeLevels_reg <= activeLevels_next;
      lastLow_reg <= lastLow_next;
      state_reg <= state_next;
      haltCnt_reg <= haltCnt_next;
      cpuHalt_reg <= (state_next == ST_WAKE);
      wakeUp_reg <= wakeStart;
    end
  end

  // outputs straight from flops
  assign coreReq = coreReq_reg;
  assign pcLoad = pcLoad_reg;
  assign pcVector = pcVector_reg;
  assign srcAck = srcAck_reg;
  assign activeLevels = activeLevels_reg;
  assign cpuHalt = cpuHalt_reg;
  assign wakeUp = wakeUp_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_halt_four;
    cpuHalt_reg [*4] ##1 !cpuHalt_reg;
  endsequence

  sequence s_load;
    ##1 (pcLoad_reg && (pcVector_reg == $past(coreReq_reg.vector)));
  endsequence

  // acknowledge loads the program counter the next cycle
  a_ack_loads_pc: assert property (ackTaken |-> s_load)
    else $error("acknowledge did not load the vector");

  // offered vector is base plus offset of the winner, relocated as set
  a_vector_sum: assert property (coreReq_reg.valid |->
      coreReq_reg.vector == mip_vec_of(reqIdx_reg, $past(vectorsInBoot), BOOT_START))
    else $error("vector is not base plus offset");

  // non-maskable wins even with all level enables off
  a_nmi_wins: assert property ((nmiPend && runOk && !activeLevels_reg[3] && !ackTaken) |=>
      (coreReq_reg.valid && coreReq_reg.rank == RANK_NMI && reqIdx_reg == NMI_SRC))
    else $error("non-maskable request not offered");

  // medium preempts a running low handler
  a_med_preempt: assert property ((activeLevels_reg == 4'h1 && winRank == RANK_MED && runOk && !ackTaken
      && !retiDone) |=> coreReq_reg.valid)
    else $error("medium did not preempt low");

  // high preempts a running medium handler
  a_high_preempt: assert property ((activeLevels_reg[3:1] == 3'h1 && winRank == RANK_HIGH && runOk
      && !ackTaken) |=> coreReq_reg.valid)
    else $error("high did not preempt medium");

  // nothing offered at or below the running level
  a_no_same_lvl: assert property (!eligible |=> !coreReq_reg.valid)
    else $error("request offered without priority");

  // lowest vector wins among pending high requests
  a_lowest_wins: assert property ((winRank == RANK_HIGH && runOk && !ackTaken) |=>
      (($past(highG) & ~mip_above(reqIdx_reg)) == (mip_mask_t'(1) << reqIdx_reg)))
    else $error("high arbitration not lowest first");

  // round robin moves past the last granted low source
  a_rr_advance: assert property ((roundRobinEn && winRank == RANK_LOW && (|lowAbove) && runOk
      && !ackTaken) |=> reqIdx_reg > $past(lastLow_reg))
    else $error("round robin did not advance");

  // granted source gets its one-cycle clear with the load
  a_src_ack: assert property (ackTaken |=> (srcAck_reg == (mip_mask_t'(1) << $past(reqIdx_reg))
      ##1 (srcAck_reg == '0 || ackTaken)))
    else $error("source acknowledge wrong");

  // wake-up holds the core four cycles, offering nothing meanwhile
  a_wake_halt: assert property (wakeUp_reg |-> s_halt_four)
    else $error("wake-up halt is not four cycles");

  // nothing is offered while the core is held after wake-up
  a_halt_no_req: assert property (cpuHalt_reg |=> !coreReq_reg.valid)
    else $error("request offered during wake-up halt");

  // program counter vector stands until the next acknowledge
  a_pc_hold: assert property (!ackTaken |=> $stable(pcVector_reg))
    else $error("program counter vector changed without acknowledge");

  // no offer in the cycle after an acknowledge, so one request is taken once
  a_ack_gap: assert property (ackTaken |=> !coreReq_reg.valid)
    else $error("request offered right after acknowledge");

endmodule : mip_prioritizer

/* dv/mip_core_model.sv */
// core-side partner of the prioritizer: takes offered requests and returns from handlers
`timescale 1ns/100ps
module mip_core_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire mip_pkg::mip_core_req_t coreReq,
  input wire logic pcLoad,
  input wire logic ackHold,
  input wire logic retiHold,
  input wire logic [3:0] runLen,
  output logic intAck,
  output logic retiDone
);
  import mip_pkg::*;
  int depth;
  logic [3:0] runCnt;

  // ****************************************
  // acknowledge and return
  // ****************************************
  // ack any offer unless stalled; one return per loaded handler, innermost first
  always @(posedge core_clk) begin
    if (!rstn) begin
      intAck <= 1'b0;
      retiDone <= 1'b0;
      depth <= 0;
      runCnt <= 4'h0;
    end else begin
      intAck <= coreReq.valid && !ackHold;
      retiDone <= 1'b0;
      if (runCnt != 4'h0) begin
        runCnt <= runCnt - 4'h1;
      end
      if (pcLoad) begin
        depth <= depth + 1;
        runCnt <= runLen;
      end else if (depth > 0 && runCnt == 4'h0 && !retiHold && !retiDone) begin
        retiDone <= 1'b1; // handler ran for runLen+1 cycles after the load
        depth <= depth - 1;
        runCnt <= runLen;
      end
    end
  end
endmodule : mip_core_model

/* dv/tb_multilevel_interrupt_prioritizer.sv */
// self-checking bench of the multilevel interrupt prioritizer against a core model
`timescale 1ns/100ps
module tb_multilevel_interrupt_prioritizer;
  import mip_pkg::*;
  localparam mip_word_addr_t BOOT_W = 16'h2000;
  localparam mip_word_addr_t EXPV [NUM_SRC] = '{16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000E,
    16'h0010, 16'h0018, 16'h001A, 16'h0024, 16'h0026, 16'h0044, 16'h0050, 16'h0052};
  localparam logic [3*NUM_SRC-1:0] ALL_LOW = {NUM_SRC{3'h5}};
  localparam int P_SRC [4] = '{4, 6, 8, 0};
  localparam logic [1:0] P_LVL [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
  localparam int P_ACT [4] = '{1, 3, 7, 15};
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [NUM_SRC-1:0] srcCond = '0;
  mip_src_cfg_t [NUM_SRC-1:0] srcCfg = ALL_LOW;
  logic [2:0] lvlEnable = 3'h7;
  logic globalIntEn = 1'b1, roundRobinEn = 1'b0, vectorsInBoot = 1'b0, sleepActive = 1'b0;
  logic ackHold = 1'b0, retiHold = 1'b0;
  logic intAck, retiDone, pcLoad, cpuHalt, wakeUp;
  mip_core_req_t coreReq;
  mip_word_addr_t pcVector;
  logic [NUM_SRC-1:0] srcAck;
  logic [3:0] activeLevels;
  int fails = 0, nTests = 0;

  mip_prioritizer #(.BOOT_START(BOOT_W)) i_dut (.core_clk(core_clk), .rstn(rstn), .srcCond(srcCond),
    .srcCfg(srcCfg), .lvlEnable(lvlEnable), .globalIntEn(globalIntEn), .roundRobinEn(roundRobinEn),
    .vectorsInBoot(vectorsInBoot), .sleepActive(sleepActive), .intAck(intAck), .retiDone(retiDone),
    .coreReq(coreReq), .pcLoad(pcLoad), .pcVector(pcVector), .srcAck(srcAck),
    .activeLevels(activeLevels), .cpuHalt(cpuHalt), .wakeUp(wakeUp));
  mip_core_model i_core (.core_clk(core_clk), .rstn(rstn), .coreReq(coreReq), .pcLoad(pcLoad),
    .ackHold(ackHold), .retiHold(retiHold), .runLen(4'h3), .intAck(intAck), .retiDone(retiDone));

  // 200 MHz clock
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick

  task automatic giveVerdict();
    $display("comparisons %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : giveVerdict

  task automatic chkWord(input string nm, input logic [15:0] e, input logic [15:0] g);
    nTests++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chkWord

  task automatic chkBit(input string nm, input logic e, input logic g);
    nTests++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask : chkBit

  // waits for a program counter load and checks vector and source acknowledge
  task automatic waitGrant(input int idx, input bit clr);
    int n;
    n = 0;
    while (pcLoad !== 1'b1 && n < 80) begin
      tick();
      n++;
    end
    if (pcLoad !== 1'b1) begin
      fails++;
      $display("unexpected grant of source %0d: expected load seen none", idx);
      giveVerdict();
    end else begin
      chkWord("pcVector", EXPV[idx] + (vectorsInBoot ? BOOT_W : 16'h0000), pcVector);
      chkWord("srcAck", 16'(13'h1 << idx), 16'(srcAck));
      if (clr) begin
        srcCond <= srcCond & ~srcAck;
      end
      tick();
    end
  endtask : waitGrant

  task automatic doReset();
    rstn <= 1'b0;
    repeat (4) tick();
    chkBit("resetValid", 1'b0, coreReq.valid);
    chkWord("resetPc", 16'h0000, pcVector);
    chkWord("resetActive", 16'h0000, 16'(activeLevels));
    chkBit("resetHalt", 1'b0, cpuHalt);
    rstn <= 1'b1;
    tick();
  endtask : doReset

  // expected winner: non-maskable, then level, then lowest vector
  function automatic void expWin(output int w, output int r);
    int k;
    w = -1;
    r = 0;
    for (int i = 0; i < NUM_SRC; i++) begin
      k = (i == 0) ? 4 * int'(srcCfg[i].enable) :
        (srcCfg[i].enable && globalIntEn && srcCfg[i].level != LVL_OFF &&
         lvlEnable[int'(srcCfg[i].level) - 1]) ? int'(srcCfg[i].level) : 0;
      if (srcCond[i] && k > r) begin
        w = i;
        r = k;
      end
    end
  endfunction : expWin

  // next pending source above the last granted one, wrapping
  function automatic int rrNext(input logic [NUM_SRC-1:0] m, input int last);
    for (int d = 1; d <= NUM_SRC; d++) begin
      if (m[(last + d) % NUM_SRC]) begin
        return (last + d) % NUM_SRC;
      end
    end
    return -1;
  endfunction : rrNext

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    int w, r, last;
    logic [NUM_SRC-1:0] m;
    void'($urandom(32'h1274));
    doReset();
    // every source alone, vector table randomly relocated
    for (int i = 0; i < NUM_SRC; i++) begin
      vectorsInBoot <= 1'($urandom);
      srcCond <= 13'h1 << i;
      waitGrant(i, 1'b1);
      repeat (8) tick();
    end
    // random mixes of levels and enables with the core stalled
    vectorsInBoot <= 1'b0;
    ackHold <= 1'b1;
    repeat (4) tick();
    for (int k = 0; k < 30; k++) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        srcCfg[i] <= {1'($urandom) | (i == 0 && k < 3), 2'($urandom)}; // non-maskable on while levels are off
      end
      srcCond <= (k == 0) ? '1 : (NUM_SRC'($urandom) | NUM_SRC'(k < 3));
      lvlEnable <= (k == 1) ? 3'h0 : 3'($urandom);
      globalIntEn <= (k != 2) && ($urandom % 4 != 0);
      repeat (3) tick();
      expWin(w, r);
      chkBit("valid", w >= 0, coreReq.valid);
      if (w >= 0) begin
        chkWord("vector", EXPV[w], coreReq.vector);
        chkWord("rank", 16'(r), 16'(coreReq.rank));
      end
    end
    // nested preemption low, medium, high, non-maskable
    srcCond <= '0;
    srcCfg <= ALL_LOW;
    lvlEnable <= 3'h7;
    globalIntEn <= 1'b1;
    ackHold <= 1'b0;
    retiHold <= 1'b1;
    repeat (4) tick();
    for (int j = 0; j < 4; j++) begin
      srcCfg[P_SRC[j]] <= {1'b1, P_LVL[j]};
      srcCond[P_SRC[j]] <= 1'b1;
      waitGrant(P_SRC[j], 1'b1);
      chkWord("activeLevels", 16'(P_ACT[j]), 16'(activeLevels));
      if (j == 0) begin
        srcCond[5] <= 1'b1;
        repeat (4) tick();
        chkBit("sameLevel", 1'b0, coreReq.valid);
      end
    end
    retiHold <= 1'b0;
    waitGrant(5, 1'b1);
    // round robin from the reset pointer over a held random set
    repeat (10) tick();
    srcCfg <= ALL_LOW;
    doReset();
    roundRobinEn <= 1'b1;
    m = (NUM_SRC'($urandom) & 13'h1FFE) | 13'h1002;
    srcCond <= m;
    last = 12;
    for (int k = 0; k < 16; k++) begin
      last = rrNext(m, last);
      waitGrant(last, 1'b0);
    end
    srcCond <= '0;
    roundRobinEn <= 1'b0;
    // wake-up with a higher request pending
    repeat (10) tick();
    srcCfg[3] <= {1'b1, LVL_HIGH};
    sleepActive <= 1'b1;
    srcCond <= 13'h0408;
    w = 0;
    while (wakeUp !== 1'b1 && w < 20) begin
      tick();
      w++;
    end
    sleepActive <= 1'b0;
    r = 0;
    while (cpuHalt === 1'b1 && r < 10) begin
      chkBit("haltValid", 1'b0, coreReq.valid);
      tick();
      r++;
    end
    chkWord("haltCycles", 16'h0004, 16'(r));
    waitGrant(3, 1'b1);
    waitGrant(10, 1'b1);
    giveVerdict();
  end

  // cuts a hung run short
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    $display("unexpected run length: expected end seen limit");
    giveVerdict();
  end
endmodule : tb_multilevel_interrupt_prioritizer
